// ---- design/cafr_top.sv ----
`timescale 1ns/1ps
`include "cafr_consts.svh"
// What this block does
// - hold flag readable, write one clears
// - user-recovery mode sets hold at bus-off
// - clearing requests recovery; reads zero then
// - receive error counter mirrored read-only
// - transmit error counter mirrored read-only
// - only accepted frames update the hit index; dropped frames still set a status event
// - code and mask applied bitwise per byte
// - 32-bit organization: extended uses four pairs, standard two
// - mask zero must match, one ignores
// - filter registers writable only in init
// - eight code and eight mask bytes
// - organization selects 32/16/8 or closed
// - hit index tracks foreground frame
module cafr_top #(
	parameter int AW = 8
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic resetn_i,
	// axi4-lite write side
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [AW-1:0] s_axi_awaddr_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	output logic [1:0] s_axi_bresp_o,
	// axi4-lite read side
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	input wire logic [AW-1:0] s_axi_araddr_i,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	// controller mode state
	input wire logic init_request_i,
	input wire logic init_acknowledge_i,
	input wire logic sleep_request_i,
	input wire logic sleep_acknowledge_i,
	input wire logic recovery_on_user_request_i,
	input wire logic bus_off_i,
	// error counters
	input wire logic [7:0] rx_err_cnt_i,
	input wire logic [7:0] tx_err_cnt_i,
	// background receive buffer
	input wire logic frame_valid_i,
	input wire logic [31:0] received_identifier_bytes_i,
	input wire logic frame_ext_i,
	// results
	output logic frame_accept_o,
	output logic frame_drop_o,
	output logic [2:0] filter_hit_index_o,
	output logic bus_off_recover_o,
	output logic irq_o
);
	import cafr_pkg::*;

	// **********************************
	// declarations
	// **********************************
	logic wr_en; // one-cycle store strobe
	logic [AW-1:0] wr_addr;
	logic [31:0] wr_data;
	logic wr_ok; // address mapped
	logic rd_en;
	logic [AW-1:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_ok;
	cafr_byte_t [7:0] code_reg; // acceptance code bytes, packed bank
	cafr_byte_t [7:0] mask_reg; // acceptance mask bytes, packed bank
	cafr_org_t org; // filter_organization
	logic bus_off_hold_flag;
	logic next_hold;
	logic rec_pend; // recovery requested, not yet left
	logic bus_off_q; // for the entry edge
	logic hold_set;
	logic hold_clr;
	logic init_mode;
	logic filt_accept;
	logic [2:0] filt_hit;
	logic [`CAFR_EV_W-1:0] ev_status; // sticky events
	logic [`CAFR_EV_W-1:0] ev_mask;
	logic [`CAFR_EV_W-1:0] ev_set;

	// address of the k-th word of a bank
	function automatic logic [AW-1:0] bank_addr(
		input logic [7:0] base, input int k);
		bank_addr = AW'(base) + AW'(k * 4);
	endfunction : bank_addr

	// true for any implemented register word
	function automatic logic mapped(input logic [AW-1:0] a);
		mapped = (a[1:0] == 2'h0) &&
			(a <= AW'(`CAFR_OFF_IMSK));
	endfunction : mapped

	// **********************************
	// bus slave
	// **********************************
	cafr_axil #(.AW(AW)) u_axil (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.s_axi_awvalid_i(s_axi_awvalid_i),
		.s_axi_awready_o(s_axi_awready_o),
		.s_axi_awaddr_i(s_axi_awaddr_i),
		.s_axi_wvalid_i(s_axi_wvalid_i),
		.s_axi_wready_o(s_axi_wready_o),
		.s_axi_wdata_i(s_axi_wdata_i),
		.s_axi_wstrb_i(s_axi_wstrb_i),
		.s_axi_bvalid_o(s_axi_bvalid_o),
		.s_axi_bready_i(s_axi_bready_i),
		.s_axi_bresp_o(s_axi_bresp_o),
		.s_axi_arvalid_i(s_axi_arvalid_i),
		.s_axi_arready_o(s_axi_arready_o),
		.s_axi_araddr_i(s_axi_araddr_i),
		.s_axi_rvalid_o(s_axi_rvalid_o),
		.s_axi_rready_i(s_axi_rready_i),
		.s_axi_rdata_o(s_axi_rdata_o),
		.s_axi_rresp_o(s_axi_rresp_o),
		.wr_en_o(wr_en),
		.wr_addr_o(wr_addr),
		.wr_data_o(wr_data),
		.wr_ok_i(wr_ok),
		.rd_en_o(rd_en),
		.rd_addr_o(rd_addr),
		.rd_data_i(rd_data),
		.rd_ok_i(rd_ok)
	);

	// unmapped or misaligned words get an error
	assign wr_ok = mapped(wr_addr);
	assign init_mode = init_request_i & init_acknowledge_i;

	// **********************************
	// filter registers
	// **********************************
	// locked outside init so a running filter
	// never sees a half-written pattern
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			for (int i = 0; i < 8; i++) begin
				code_reg[i] <= `CAFR_RST_BYTE;
				mask_reg[i] <= `CAFR_RST_BYTE;
			end
		end else if (wr_en & init_mode) begin
			for (int i = 0; i < 8; i++) begin
				if (wr_addr == bank_addr(`CAFR_OFF_CODE0, i)) begin
					code_reg[i] <= wr_data[7:0];
				end
				if (wr_addr == bank_addr(`CAFR_OFF_MASK0, i)) begin
					mask_reg[i] <= wr_data[7:0];
				end
			end
		end
	end

	// organization shares the init-only lock
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			org <= CAFR_ORG_32;
		end else if (wr_en & init_mode &&
			wr_addr == AW'(`CAFR_OFF_FCTL)) begin
			org <= cafr_org_t'(
				wr_data[`CAFR_FCTL_ORG_LSB +: 2]);
		end
	end

	// **********************************
	// acceptance filter
	// **********************************
	cafr_filter u_filter (
		.org_i(org),
		.code_i(code_reg),
		.mask_i(mask_reg),
		.id_i(received_identifier_bytes_i),
		.ext_i(frame_ext_i),
		.accept_o(filt_accept),
		.hit_o(filt_hit)
	);

	// verdict per background frame; a dropped
	// frame is simply left to be overwritten
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			frame_accept_o <= 1'b0;
			frame_drop_o <= 1'b0;
		end else begin
			frame_accept_o <= frame_valid_i & filt_accept;
			frame_drop_o <= frame_valid_i & ~filt_accept;
		end
	end

	// accepted frame moves to foreground here
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			filter_hit_index_o <= `CAFR_RST_HIT;
		end else if (frame_valid_i & filt_accept) begin
			filter_hit_index_o <= filt_hit;
		end
	end

	// **********************************
	// bus-off hold
	// **********************************
	assign hold_set = bus_off_i & ~bus_off_q &
		recovery_on_user_request_i;
	assign hold_clr = wr_en && wr_addr == AW'(`CAFR_OFF_MISC) &&
		wr_data[`CAFR_BIT_HOLD];

	// entry-set wins over a same-cycle clear;
	// leaving bus-off drops the flag too
	always_comb begin
		next_hold = bus_off_hold_flag;
		if (hold_set) begin
			next_hold = 1'b1;
		end else if (hold_clr | ~bus_off_i) begin
			next_hold = 1'b0;
		end
	end

	// hold flag and edge history
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			bus_off_hold_flag <= 1'b0;
			bus_off_q <= 1'b0;
		end else begin
			bus_off_hold_flag <= next_hold;
			bus_off_q <= bus_off_i;
		end
	end

	// recovery request stays up until bus-off ends
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			rec_pend <= 1'b0;
		end else if (~bus_off_i) begin
			rec_pend <= 1'b0;
		end else if (hold_clr & bus_off_hold_flag & ~hold_set) begin
			rec_pend <= 1'b1;
		end
	end
	assign bus_off_recover_o = rec_pend;

	// **********************************
	// interrupts
	// **********************************
	assign ev_set[`CAFR_EV_ACC] = frame_accept_o;
	assign ev_set[`CAFR_EV_DROP] = frame_drop_o;
	assign ev_set[`CAFR_EV_HOLD] = hold_set;

	// sticky status, write one clears, set wins
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			ev_status <= `CAFR_RST_EV;
		end else if (wr_en && wr_addr == AW'(`CAFR_OFF_STAT)) begin
			ev_status <= (ev_status &
				~wr_data[`CAFR_EV_W-1:0]) | ev_set;
		end else begin
			ev_status <= ev_status | ev_set;
		end
	end

	// mask register, plain read/write
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			ev_mask <= `CAFR_RST_EV;
		end else if (wr_en && wr_addr == AW'(`CAFR_OFF_IMSK)) begin
			ev_mask <= wr_data[`CAFR_EV_W-1:0];
		end
	end
	assign irq_o = |(ev_status & ev_mask);

	// **********************************
	// read mux
	// **********************************
	// counters are live mirrors; their value is
	// only trusted in sleep or init mode
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_ok = mapped(rd_addr);
		case (rd_addr)
			AW'(`CAFR_OFF_MISC): rd_data[`CAFR_BIT_HOLD] = bus_off_hold_flag;
			AW'(`CAFR_OFF_RXERR): rd_data[7:0] = rx_err_cnt_i;
			AW'(`CAFR_OFF_TXERR): rd_data[7:0] = tx_err_cnt_i;
			AW'(`CAFR_OFF_FCTL): begin
				rd_data[`CAFR_FCTL_ORG_LSB +: 2] = org;
				rd_data[`CAFR_FCTL_HIT_LSB +: 3] =
					filter_hit_index_o;
			end
			AW'(`CAFR_OFF_STAT): rd_data[`CAFR_EV_W-1:0] = ev_status;
			AW'(`CAFR_OFF_IMSK): rd_data[`CAFR_EV_W-1:0] = ev_mask;
			default: begin
				for (int i = 0; i < 8; i++) begin
					if (rd_addr == bank_addr(`CAFR_OFF_CODE0, i)) begin
						rd_data[7:0] = code_reg[i];
					end
					if (rd_addr == bank_addr(`CAFR_OFF_MASK0, i)) begin
						rd_data[7:0] = mask_reg[i];
					end
				end
			end
		endcase
	end

	// **********************************
	// checks
	// **********************************
	a_hold_entry: assert property (@(posedge mclk_i)
		disable iff (!resetn_i)
		bus_off_i & ~bus_off_q & recovery_on_user_request_i |=> bus_off_hold_flag)
		else $error("hold flag not set at bus-off entry");
	a_hold_w1c: assert property (@(posedge mclk_i)
		disable iff (!resetn_i)
		hold_clr & ~hold_set |=> !bus_off_hold_flag)
		else $error("write one did not clear hold flag");
	a_hold_zero_ign: assert property (@(posedge mclk_i)
		disable iff (!resetn_i)
		bus_off_hold_flag & bus_off_i & ~hold_clr |=> bus_off_hold_flag)
		else $error("hold flag lost without a clear");
	a_pend_reads_zero: assert property (@(posedge mclk_i)
		disable iff (!resetn_i)
		hold_clr & bus_off_hold_flag & bus_off_i & ~hold_set
		|=> bus_off_recover_o && !bus_off_hold_flag)
		else $error("recovery request not raised");
	a_code_locked: assert property (@(posedge mclk_i)
		disable iff (!resetn_i)
		wr_en & ~init_mode |=> code_reg[0] == $past(code_reg[0])
		&& mask_reg[7] == $past(mask_reg[7]))
		else $error("filter register written outside init");
	a_drop_quiet: assert property (@(posedge mclk_i)
		disable iff (!resetn_i)
		frame_valid_i & ~filt_accept
		|=> frame_drop_o && !frame_accept_o && $stable(filter_hit_index_o))
		else $error("dropped frame notified");
	a_hit_update: assert property (@(posedge mclk_i)
		disable iff (!resetn_i)
		frame_valid_i & filt_accept
		|=> filter_hit_index_o == $past(filt_hit))
		else $error("hit index not updated");
	a_closed_none: assert property (@(posedge mclk_i)
		disable iff (!resetn_i)
		frame_valid_i && org == CAFR_ORG_CLOSED
		|=> !frame_accept_o)
		else $error("closed filter accepted a frame");
	a_dontcare_pass: assert property (@(posedge mclk_i)
		disable iff (!resetn_i)
		frame_valid_i && org == CAFR_ORG_8 && mask_reg[3] == 8'hFF
		|=> frame_accept_o && filter_hit_index_o <= 3'h3)
		else $error("all-ignore filter did not accept");
	a_std_two_pairs: assert property (@(posedge mclk_i)
		disable iff (!resetn_i)
		frame_valid_i && !frame_ext_i && org == CAFR_ORG_32 &&
		mask_reg[0] == 8'hFF && mask_reg[1] == 8'hFF
		|=> frame_accept_o && filter_hit_index_o == 3'h0)
		else $error("standard frame checked beyond two pairs");
	a_event_sticky: assert property (@(posedge mclk_i)
		disable iff (!resetn_i)
		frame_accept_o |=> ev_status[`CAFR_EV_ACC])
		else $error("accept event not latched");
endmodule : cafr_top

// ---- design/cafr_consts.svh ----
`ifndef CAFR_CONSTS_SVH
`define CAFR_CONSTS_SVH
// register byte offsets
`define CAFR_OFF_MISC 8'h00
`define CAFR_OFF_RXERR 8'h04
`define CAFR_OFF_TXERR 8'h08
`define CAFR_OFF_FCTL 8'h0C
`define CAFR_OFF_CODE0 8'h10
`define CAFR_OFF_MASK0 8'h30
`define CAFR_OFF_STAT 8'h50
`define CAFR_OFF_IMSK 8'h54
`define CAFR_REG_STEP 8'h04
// field positions
`define CAFR_BIT_HOLD 0
`define CAFR_FCTL_ORG_LSB 4
`define CAFR_FCTL_HIT_LSB 0
`define CAFR_EV_ACC 0
`define CAFR_EV_DROP 1
`define CAFR_EV_HOLD 2
`define CAFR_EV_W 3
// reset values
`define CAFR_RST_BYTE 8'h00
`define CAFR_RST_HIT 3'h0
`define CAFR_RST_EV 3'h0
// bus answers
`define CAFR_RESP_OKAY 2'h0
`define CAFR_RESP_SLVERR 2'h2
`endif

// ---- design/cafr_pkg.sv ----
package cafr_pkg;
	// filter organization codes
	typedef enum logic [1:0] {
		CAFR_ORG_32 = 2'h0,
		CAFR_ORG_16 = 2'h1,
		CAFR_ORG_8 = 2'h2,
		CAFR_ORG_CLOSED = 2'h3
	} cafr_org_t;
	typedef logic [7:0] cafr_byte_t;
endpackage : cafr_pkg

// ---- design/cafr_filter.sv ----
`timescale 1ns/1ps
// **********************************
// identifier acceptance filter bank
// **********************************
module cafr_filter (
	// filter setup
	input wire cafr_pkg::cafr_org_t org_i,
	input wire logic [63:0] code_i,
	input wire logic [63:0] mask_i,
	// received identifier
	input wire logic [31:0] id_i,
	input wire logic ext_i,
	// result
	output logic accept_o,
	output logic [2:0] hit_o
);
	import cafr_pkg::*;

	// one byte compare; mask one is don't care
	function automatic logic bm(input cafr_byte_t id,
		input cafr_byte_t c, input cafr_byte_t m);
		bm = ((id ^ c) & ~m) == 8'h00;
	endfunction : bm

	// byte k of a packed register bank
	function automatic cafr_byte_t pick(input logic [63:0] v,
		input int k);
		pick = v[8*k +: 8];
	endfunction : pick

	// descending scan so the lowest filter wins
	always_comb begin
		logic ok;
		ok = 1'b0;
		accept_o = 1'b0;
		hit_o = 3'h0;
		case (org_i)
			CAFR_ORG_32: begin
				for (int f = 1; f >= 0; f--) begin
					// standard frames use first two pairs only
					ok = bm(id_i[31:24], pick(code_i, 4*f),
						pick(mask_i, 4*f)) &
						bm(id_i[23:16], pick(code_i, 4*f+1),
						pick(mask_i, 4*f+1)) &
						(!ext_i |
						(bm(id_i[15:8], pick(code_i, 4*f+2),
						pick(mask_i, 4*f+2)) &
						bm(id_i[7:0], pick(code_i, 4*f+3),
						pick(mask_i, 4*f+3))));
					if (ok) begin
						accept_o = 1'b1;
						hit_o = 3'(f);
					end
				end
			end
			CAFR_ORG_16: begin
				for (int f = 3; f >= 0; f--) begin
					ok = bm(id_i[31:24], pick(code_i, 2*f),
						pick(mask_i, 2*f)) &
						bm(id_i[23:16], pick(code_i, 2*f+1),
						pick(mask_i, 2*f+1));
					if (ok) begin
						accept_o = 1'b1;
						hit_o = 3'(f);
					end
				end
			end
			CAFR_ORG_8: begin
				for (int f = 7; f >= 0; f--) begin
					ok = bm(id_i[31:24], pick(code_i, f),
						pick(mask_i, f));
					if (ok) begin
						accept_o = 1'b1;
						hit_o = 3'(f);
					end
				end
			end
			default: begin
				// closed: nothing is accepted
				accept_o = 1'b0;
			end
		endcase
	end
endmodule : cafr_filter

// ---- design/cafr_axil.sv ----
`timescale 1ns/1ps
`include "cafr_consts.svh"
// **********************************
// axi4-lite slave front end
// **********************************
module cafr_axil #(
	parameter int AW = 8
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic resetn_i,
	// axi write side
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [AW-1:0] s_axi_awaddr_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	output logic [1:0] s_axi_bresp_o,
	// axi read side
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	input wire logic [AW-1:0] s_axi_araddr_i,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	// register file side
	output logic wr_en_o,
	output logic [AW-1:0] wr_addr_o,
	output logic [31:0] wr_data_o,
	input wire logic wr_ok_i,
	output logic rd_en_o,
	output logic [AW-1:0] rd_addr_o,
	input wire logic [31:0] rd_data_i,
	input wire logic rd_ok_i
);
	if (AW < 7) begin : g_chk
		$error("cafr_axil: AW must be at least 7");
	end

	logic aw_full; // address held
	logic w_full; // data held
	logic [3:0] strb;

	// address and data are taken in either order
	assign s_axi_awready_o = !aw_full;
	assign s_axi_wready_o = !w_full;
	assign wr_en_o = aw_full & w_full & !s_axi_bvalid_o & strb[0];
	assign s_axi_arready_o = !s_axi_rvalid_o;
	assign rd_en_o = s_axi_arvalid_i & !s_axi_rvalid_o;
	assign rd_addr_o = s_axi_araddr_i;

	// write capture and response
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			wr_addr_o <= '0;
			wr_data_o <= 32'h0000_0000;
			strb <= 4'h0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= `CAFR_RESP_OKAY;
		end else begin
			if (s_axi_awvalid_i & !aw_full) begin
				aw_full <= 1'b1;
				wr_addr_o <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i & !w_full) begin
				w_full <= 1'b1;
				wr_data_o <= s_axi_wdata_i;
				strb <= s_axi_wstrb_i;
			end
			if (aw_full & w_full & !s_axi_bvalid_o) begin
				// byte lane 0 off: nothing stored
				aw_full <= 1'b0;
				w_full <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o <= wr_ok_i ? `CAFR_RESP_OKAY :
					`CAFR_RESP_SLVERR;
			end
			if (s_axi_bvalid_o & s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
			end
		end
	end

	// read data registered one cycle after address
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h0000_0000;
			s_axi_rresp_o <= `CAFR_RESP_OKAY;
		end else if (rd_en_o) begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rdata_o <= rd_ok_i ? rd_data_i : 32'h0000_0000;
			s_axi_rresp_o <= rd_ok_i ? `CAFR_RESP_OKAY :
				`CAFR_RESP_SLVERR;
		end else if (s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
		end
	end

	a_rd_hold: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		s_axi_rvalid_o & !s_axi_rready_i |=>
		s_axi_rvalid_o && $stable(s_axi_rdata_o))
		else $error("read answer dropped before ready");
endmodule : cafr_axil

// ---- verification/cafr_node_model.sv ----
`timescale 1ns/1ps
// ****
// remote node: one frame per send request
// ****
module cafr_node_model (
	// clock
	input wire logic mclk_i,
	// request from the bench
	input wire logic send_i,
	input wire logic [31:0] id_i,
	input wire logic ext_i,
	// toward the receive buffer
	output logic frame_valid_o,
	output logic [31:0] ident_o,
	output logic ext_o
);
	// quiet line at time zero
	initial begin
		frame_valid_o = 1'b0;
		ident_o = 32'h0;
		ext_o = 1'b0;
	end
	// frame stands one cycle; idle bytes and ext flip every cycle, so a stale id can still match a filter while frame_valid_o is low
	always @(posedge mclk_i) begin
		frame_valid_o <= send_i;
		ident_o <= send_i ? id_i : ~ident_o;
		ext_o <= send_i ? ext_i : ~ext_o;
	end
endmodule : cafr_node_model

// ---- verification/can_acceptance_filter_regs_bench.sv ----
`timescale 1ns/1ps
`include "cafr_consts.svh"
module can_acceptance_filter_regs_bench;
	import cafr_pkg::*;
	// ****
	// signals
	// ****
	logic mclk_i, resetn_i, s_axi_awvalid_i, s_axi_awready_o;
	logic s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i;
	logic s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
	logic [7:0] s_axi_awaddr_i, s_axi_araddr_i, rx_err_cnt_i, tx_err_cnt_i;
	logic [31:0] s_axi_wdata_i, s_axi_rdata_o, received_identifier_bytes_i;
	logic [3:0] s_axi_wstrb_i;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rs, org;
	logic init_request_i, init_acknowledge_i, sleep_request_i;
	logic sleep_acknowledge_i, recovery_on_user_request_i, bus_off_i;
	logic frame_valid_i, frame_ext_i, frame_accept_o, frame_drop_o;
	logic bus_off_recover_o, irq_o, send, send_ext;
	logic [2:0] filter_hit_index_o, hit;
	logic [31:0] send_id, q;
	cafr_byte_t code [8]; // shadow of filter setup
	cafr_byte_t mask [8];
	int bad_count, compares;
	cafr_top i_cafr_top (.mclk_i, .resetn_i, .s_axi_awvalid_i,
		.s_axi_awready_o, .s_axi_awaddr_i, .s_axi_wvalid_i, .s_axi_wready_o,
		.s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_bvalid_o, .s_axi_bready_i,
		.s_axi_bresp_o, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_araddr_i,
		.s_axi_rvalid_o, .s_axi_rready_i, .s_axi_rdata_o, .s_axi_rresp_o,
		.init_request_i, .init_acknowledge_i, .sleep_request_i,
		.sleep_acknowledge_i, .recovery_on_user_request_i, .bus_off_i,
		.rx_err_cnt_i, .tx_err_cnt_i, .frame_valid_i,
		.received_identifier_bytes_i, .frame_ext_i, .frame_accept_o,
		.frame_drop_o, .filter_hit_index_o, .bus_off_recover_o, .irq_o);
	cafr_node_model i_cafr_node_model (.mclk_i, .send_i(send),
		.id_i(send_id), .ext_i(send_ext), .frame_valid_o(frame_valid_i),
		.ident_o(received_identifier_bytes_i), .ext_o(frame_ext_i));
	// 10 mhz clock
	initial begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end
	// ****
	// tasks
	// ****
	task automatic complete_run();
		if (bad_count == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			bad_count++;
			$display("wrong value at %0t: got %h want %h", $time, s, e);
		end
	endtask : chk
	// one axi cycle; handshakes read at the negedge before the edge
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		logic pa, pw, ha, hw, dn;
		int n;
		@(posedge mclk_i);
		s_axi_awvalid_i <= wr;
		s_axi_wvalid_i <= wr;
		s_axi_bready_i <= wr;
		s_axi_arvalid_i <= !wr;
		s_axi_rready_i <= !wr;
		s_axi_awaddr_i <= a;
		s_axi_araddr_i <= a;
		s_axi_wdata_i <= d;
		pa = 1'b1;
		pw = wr;
		dn = 1'b0;
		n = 0;
		while ((pa || pw || !dn) && n < 200) begin
			@(negedge mclk_i);
			ha = wr ? s_axi_awready_o : s_axi_arready_o;
			hw = s_axi_wready_o;
			dn = wr ? s_axi_bvalid_o : s_axi_rvalid_o;
			q = s_axi_rdata_o;
			rs = wr ? s_axi_bresp_o : s_axi_rresp_o;
			@(posedge mclk_i);
			if (pa && ha) begin
				pa = 1'b0;
				s_axi_awvalid_i <= 1'b0;
				s_axi_arvalid_i <= 1'b0;
			end
			if (pw && hw) begin
				pw = 1'b0;
				s_axi_wvalid_i <= 1'b0;
			end
			n++;
		end
		s_axi_bready_i <= 1'b0;
		s_axi_rready_i <= 1'b0;
		@(negedge mclk_i);
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
		chk(rs, `CAFR_RESP_OKAY);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask : rd
	task automatic mode(input logic m);
		@(posedge mclk_i);
		init_request_i <= m;
		init_acknowledge_i <= m;
		@(negedge mclk_i);
	endtask : mode
	// expected {accept, hit}; lowest filter wins
	function automatic logic [3:0] exp_hit(logic [31:0] id, logic ext);
		int nf, st, nb, i;
		logic ok;
		exp_hit = 4'h0;
		nf = (org == 2'h3) ? 0 : 2 << org;
		st = 4 >> org;
		nb = (org == 2'h2) ? 1 : ((org == 2'h0 && ext) ? 4 : 2);
		for (int f = nf - 1; f >= 0; f--) begin
			ok = 1'b1;
			for (int b = 0; b < nb; b++) begin
				i = f * st + b;
				if (((id[31 - 8 * b -: 8] ^ code[i]) & ~mask[i]) != 8'h00) begin
					ok = 1'b0;
				end
			end
			if (ok) exp_hit = {1'b1, 3'(f)};
		end
	endfunction : exp_hit
	task automatic frame(input logic [31:0] id, input logic ext);
		logic [3:0] e;
		e = exp_hit(id, ext);
		@(posedge mclk_i);
		send <= 1'b1;
		send_id <= id;
		send_ext <= ext;
		@(posedge mclk_i);
		send <= 1'b0;
		@(posedge mclk_i);
		@(negedge mclk_i);
		if (e[3]) hit = e[2:0];
		chk(frame_accept_o, e[3]);
		chk(frame_drop_o, !e[3]);
		chk(filter_hit_index_o, hit);
	endtask : frame
	// hang guard
	initial begin
		#3000000;
		bad_count++;
		complete_run();
	end
	// ****
	// main sequence
	// ****
	initial begin
		logic [31:0] id;
		int k, j;
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 3'h0;
		{s_axi_arvalid_i, s_axi_rready_i, send, send_ext} = 4'h0;
		{s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i, send_id} = 80'h0;
		{init_request_i, init_acknowledge_i, bus_off_i} = 3'h0;
		{sleep_request_i, sleep_acknowledge_i} = 2'h0;
		recovery_on_user_request_i = 1'b0;
		{rx_err_cnt_i, tx_err_cnt_i} = 16'h0;
		s_axi_wstrb_i = 4'hF;
		resetn_i = 1'b0;
		hit = 3'h0;
		void'($urandom(7));
		repeat (10) @(posedge mclk_i);
		resetn_i <= 1'b1;
		// reset values, then an unmapped place
		for (int i = 0; i < 16; i++) rd(8'(8'h10 + 4 * i), 32'h0);
		rd(`CAFR_OFF_FCTL, 32'h0);
		bus(1'b0, 8'h58, 32'h0);
		chk(rs, `CAFR_RESP_SLVERR);
		bus(1'b1, 8'h5A, 32'h0);
		chk(rs, `CAFR_RESP_SLVERR);
		// counters mirrored read-only, read in init mode
		mode(1'b1);
		@(posedge mclk_i);
		rx_err_cnt_i <= 8'($urandom);
		tx_err_cnt_i <= 8'($urandom);
		wr(`CAFR_OFF_RXERR, 32'h0);
		wr(`CAFR_OFF_TXERR, 32'h0);
		rd(`CAFR_OFF_RXERR, {24'h0, rx_err_cnt_i});
		rd(`CAFR_OFF_TXERR, {24'h0, tx_err_cnt_i});
		// bus-off hold and user recovery
		@(posedge mclk_i);
		recovery_on_user_request_i <= 1'b1;
		bus_off_i <= 1'b1;
		rd(`CAFR_OFF_MISC, 32'h1);
		wr(`CAFR_OFF_MISC, 32'h0);
		rd(`CAFR_OFF_MISC, 32'h1);
		wr(`CAFR_OFF_MISC, 32'h1);
		rd(`CAFR_OFF_MISC, 32'h0);
		chk(bus_off_recover_o, 1'b1);
		rd(`CAFR_OFF_STAT, 32'h4);
		wr(`CAFR_OFF_STAT, 32'h4);
		@(posedge mclk_i);
		bus_off_i <= 1'b0;
		rd(`CAFR_OFF_STAT, 32'h0);
		chk(bus_off_recover_o, 1'b0);
		// second entry, left again without any clear
		@(posedge mclk_i);
		bus_off_i <= 1'b1;
		rd(`CAFR_OFF_MISC, 32'h1);
		@(posedge mclk_i);
		bus_off_i <= 1'b0;
		rd(`CAFR_OFF_MISC, 32'h0);
		wr(`CAFR_OFF_STAT, 32'h4);
		// every organization with random filters and frames
		for (int o = 0; o < 4; o++) begin
			mode(1'b1);
			org = o[1:0];
			wr(`CAFR_OFF_FCTL, {26'h0, org, 4'h0});
			for (int i = 0; i < 8; i++) begin
				code[i] = cafr_byte_t'($urandom);
				mask[i] = cafr_byte_t'($urandom | $urandom);
			end
			mask[1] |= 8'h07;
			mask[5] |= 8'h07;
			mask[3] |= 8'h07;
			mask[7] |= 8'h07;
			// corner cases: all-ignore pairs
			if (o == 0) {mask[0], mask[1]} = 16'hFFFF;
			if (o == 2) mask[3] = 8'hFF;
			for (int i = 0; i < 8; i++) begin
				wr(8'(8'h10 + 4 * i), {24'hFFFFFF, code[i]});
				wr(8'(8'h30 + 4 * i), {24'hFFFFFF, mask[i]});
			end
			// byte lane 0 off: write answered, nothing stored
			@(posedge mclk_i);
			s_axi_wstrb_i <= 4'hE;
			wr(`CAFR_OFF_CODE0, {24'h0, ~code[0]});
			@(posedge mclk_i);
			s_axi_wstrb_i <= 4'hF;
			mode(1'b0);
			wr(`CAFR_OFF_CODE0, {24'h0, ~code[0]});
			for (int i = 0; i < 8; i++) begin
				rd(8'(8'h10 + 4 * i), {24'h0, code[i]});
				rd(8'(8'h30 + 4 * i), {24'h0, mask[i]});
			end
			rd(`CAFR_OFF_FCTL, {26'h0, org, 1'b0, hit});
			if (o == 0) begin
				// interrupt raised, cleared, then masked
				wr(`CAFR_OFF_IMSK, 32'h1);
				frame({code[0], code[1], code[2], code[3]}, 1'b1);
				rd(`CAFR_OFF_STAT, 32'h1);
				chk(irq_o, 1'b1);
				wr(`CAFR_OFF_STAT, 32'h1);
				chk(irq_o, 1'b0);
				wr(`CAFR_OFF_IMSK, 32'h0);
				frame({code[0], code[1], code[2], code[3]}, 1'b1);
				rd(`CAFR_OFF_STAT, 32'h1);
				chk(irq_o, 1'b0);
				wr(`CAFR_OFF_STAT, 32'h7);
			end
			repeat (24) begin
				k = $urandom_range(7);
				for (int b = 0; b < 4; b++) begin
					j = (k * (4 >> org) + b) & 7;
					id[31 - 8 * b -: 8] = code[j] ^ (8'($urandom) & mask[j]);
				end
				if ($urandom_range(2) == 0) id = id ^ (32'h1 << $urandom_range(31));
				frame(id, 1'($urandom_range(1)));
			end
		end
		complete_run();
	end
endmodule : can_acceptance_filter_regs_bench
